// file: rbsc_cfg.svh
// Constants of the radio basic state controller.
`ifndef RBSC_CFG_SVH
`define RBSC_CFG_SVH
`define RBSC_ADDR_CMD 4'h0
`define RBSC_ADDR_STATUS 4'h1
`define RBSC_ADDR_PIN 4'h2
`define RBSC_ADDR_EVENT 4'h3
`define RBSC_ADDR_CHANNEL 4'h4
`define RBSC_ADDR_RXINFO 4'h5
`define RBSC_PIN_SLEEP_BIT 0
`define RBSC_PIN_RESET_BIT 1
`define RBSC_CMD_NOP 5'h00
`define RBSC_CMD_TX_START 5'h02
`define RBSC_CMD_FORCE_OFF 5'h03
`define RBSC_CMD_FORCE_PLL 5'h04
`define RBSC_CMD_RX_ON 5'h06
`define RBSC_CMD_OFF 5'h08
`define RBSC_CMD_PLL_ON 5'h09
`define RBSC_ST_BUSY_RX 5'h01
`define RBSC_ST_BUSY_TX 5'h02
`define RBSC_ST_RX_ON 5'h06
`define RBSC_ST_OFF 5'h08
`define RBSC_ST_PLL_ON 5'h09
`define RBSC_ST_SLEEP 5'h0F
`define RBSC_ST_PENDING 5'h1F
`define RBSC_CHANNEL_RST 5'h0B
`define RBSC_CLK_MHZ 10
`define RBSC_TX_RAMP_US 16
`define RBSC_TX_RAMP_CYC ((`RBSC_TX_RAMP_US * `RBSC_CLK_MHZ))
`define RBSC_REG_SETTLE_CYC 8
`define RBSC_PLL_SETTLE_CYC 16
`define RBSC_CNT_W 8
`define RBSC_EV_AWAKE 0
`define RBSC_EV_LOCK 1
`define RBSC_EV_RXSTART 2
`define RBSC_EV_RXEND 3
`define RBSC_EV_TXEND 4
`define RBSC_EV_AMATCH 5
`endif

// file: rbsc_pkg.sv
// Types of the radio basic state controller.
`default_nettype none
package rbsc_pkg;
  typedef enum logic [2:0] {
    RBSC_SLEEP,
    RBSC_OFF,
    RBSC_PLL,
    RBSC_RX_LISTEN,
    RBSC_BUSY_RX,
    RBSC_BUSY_TX
  } rbsc_state_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rbsc_bus_t;
  typedef struct packed {
    logic shrFound;
    logic phrValid;
    logic addrMatch;
    logic frameDone;
    logic crcOk;
    logic txDone;
  } rbsc_phy_t;
endpackage
`default_nettype wire

// file: rbsc_timer.sv
// Down-counter that pulses once when a loaded delay has elapsed.
`default_nettype none
`include "rbsc_cfg.svh"
module rbsc_timer
  import rbsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [`RBSC_CNT_W-1:0] count,
  input wire logic cancel,
  output logic done
);
  logic [`RBSC_CNT_W-1:0] cnt_r;
  logic run_r;
  assign done = run_r && (cnt_r == 8'h01);
  always_ff @(posedge ref_clk)
  begin
    if (rst || cancel)
    begin
      run_r <= 1'b0;
      cnt_r <= 8'h00;
    end
    else if (load)
    begin
      run_r <= 1'b1;
      cnt_r <= count;
    end
    else if (run_r)
    begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01)
        run_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: rbsc_ctrl.sv
// Basic-mode state controller of the 2.4 GHz radio with its register port.
`default_nettype none
`include "rbsc_cfg.svh"
module rbsc_ctrl
  import rbsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire rbsc_bus_t bus,
  output logic [7:0] rdata,
  input wire rbsc_phy_t phy,
  output logic regulatorOn,
  output logic synthOn,
  output logic rxOn,
  output logic paOn,
  output logic txChipStart,
  output logic bufferWrite,
  output logic memClear,
  output logic frontEndOn,
  output logic [4:0] channel,
  output logic [5:0] events
);
  rbsc_state_t state_r, state_nxt;
  logic [4:0] cmd_r;
  logic sleepTx_r;
  logic sleepTxPrev_r;
  logic [4:0] channel_r;
  logic crcValid_r;
  logic offPending_r;
  logic locked_r;
  logic regReady_r;
  logic inTransit_r;
  logic txSending_r;
  logic [7:0] rdata_r;
  logic [5:0] events_r;
  logic [5:0] eventsSet;
  logic [7:0] readMux;
  logic [4:0] statusCode;
  logic [4:0] stableCode;

  // Write decoding.
  wire cmdWrite = bus.wr && (bus.addr == `RBSC_ADDR_CMD);
  wire pinWrite = bus.wr && (bus.addr == `RBSC_ADDR_PIN);
  wire chanWrite = bus.wr && (bus.addr == `RBSC_ADDR_CHANNEL);
  wire [4:0] newCmd = bus.wdata[4:0];
  // The reset bit is self-clearing: it is never stored, only acted upon.
  wire softReset = pinWrite && bus.wdata[`RBSC_PIN_RESET_BIT];
  wire radioReset = rst || softReset;
  wire sleepRise = sleepTx_r && !sleepTxPrev_r;
  wire sleepFall = !sleepTx_r && sleepTxPrev_r;
  wire isBusy = (state_r == RBSC_BUSY_RX) || (state_r == RBSC_BUSY_TX);
  wire forceOff = cmdWrite && (newCmd == `RBSC_CMD_FORCE_OFF);
  wire plainOff = cmdWrite && (newCmd == `RBSC_CMD_OFF);
  wire forcePll = cmdWrite && (newCmd == `RBSC_CMD_FORCE_PLL);
  wire pllCmd = cmdWrite && (newCmd == `RBSC_CMD_PLL_ON);
  wire rxCmd = cmdWrite && (newCmd == `RBSC_CMD_RX_ON);
  wire txCmd = cmdWrite && (newCmd == `RBSC_CMD_TX_START);
  wire rxDone = (state_r == RBSC_BUSY_RX) && phy.frameDone;
  wire txDone = (state_r == RBSC_BUSY_TX) && phy.txDone && txSending_r;
  wire activityDone = rxDone || txDone;

  // Timers for regulator settling, synthesizer settling and transmit ramp.
  wire enterPll = (state_r == RBSC_OFF) && pllCmd;
  wire enterTx = (state_r == RBSC_PLL) && (sleepRise || txCmd);
  wire leaveAnalog = (state_nxt == RBSC_OFF) || (state_nxt == RBSC_SLEEP);
  wire regDone;
  wire pllDone;
  wire rampDone;
  rbsc_timer u_regTimer (
    .ref_clk(ref_clk),
    .rst(radioReset),
    .load(enterPll),
    .count(8'(`RBSC_REG_SETTLE_CYC)),
    .cancel(leaveAnalog),
    .done(regDone)
  );
  rbsc_timer u_pllTimer (
    .ref_clk(ref_clk),
    .rst(radioReset),
    .load(regDone),
    .count(8'(`RBSC_PLL_SETTLE_CYC)),
    .cancel(leaveAnalog),
    .done(pllDone)
  );
  rbsc_timer u_rampTimer (
    .ref_clk(ref_clk),
    .rst(radioReset),
    .load(enterTx),
    .count(8'(`RBSC_TX_RAMP_CYC)),
    .cancel(state_nxt != RBSC_BUSY_TX),
    .done(rampDone)
  );

  // Next-state logic.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      RBSC_SLEEP:
        if (sleepFall)
          state_nxt = RBSC_OFF;
      RBSC_OFF:
        if (sleepRise)
          state_nxt = RBSC_SLEEP;
        else if (pllCmd)
          state_nxt = RBSC_PLL;
      RBSC_PLL:
        if (forceOff || plainOff)
          state_nxt = RBSC_OFF;
        else if (rxCmd)
          state_nxt = RBSC_RX_LISTEN;
        else if (sleepRise || txCmd)
          state_nxt = RBSC_BUSY_TX;
      RBSC_RX_LISTEN:
        if (forceOff || plainOff)
          state_nxt = RBSC_OFF;
        else if (forcePll || pllCmd)
          state_nxt = RBSC_PLL;
        else if (phy.shrFound && locked_r)
          state_nxt = RBSC_BUSY_RX;
      RBSC_BUSY_RX:
        if (forceOff)
          state_nxt = RBSC_OFF;
        else if (forcePll)
          state_nxt = RBSC_PLL;
        else if (rxDone)
          state_nxt = (offPending_r || plainOff) ? RBSC_OFF : RBSC_RX_LISTEN;
      RBSC_BUSY_TX:
        if (forceOff)
          state_nxt = RBSC_OFF;
        else if (forcePll)
          state_nxt = RBSC_PLL;
        else if (txDone)
          state_nxt = (offPending_r || plainOff) ? RBSC_OFF : RBSC_PLL;
      default:
        state_nxt = RBSC_OFF;
    endcase
  end

  // Stable codes are all distinct and none equals the pending code.
  assign stableCode = (state_r == RBSC_SLEEP) ? `RBSC_ST_SLEEP :
                      (state_r == RBSC_PLL) ? `RBSC_ST_PLL_ON :
                      (state_r == RBSC_RX_LISTEN) ? `RBSC_ST_RX_ON :
                      (state_r == RBSC_BUSY_RX) ? `RBSC_ST_BUSY_RX :
                      (state_r == RBSC_BUSY_TX) ? `RBSC_ST_BUSY_TX : `RBSC_ST_OFF;
  assign statusCode = inTransit_r ? `RBSC_ST_PENDING : stableCode;

  // Events pulse for one cycle.
  wire enterOffFromSleep = (state_r == RBSC_SLEEP) && (state_nxt == RBSC_OFF);
  assign eventsSet[`RBSC_EV_AWAKE] = enterOffFromSleep;
  assign eventsSet[`RBSC_EV_LOCK] = pllDone;
  assign eventsSet[`RBSC_EV_RXSTART] = (state_r == RBSC_BUSY_RX) && phy.phrValid;
  assign eventsSet[`RBSC_EV_RXEND] = rxDone;
  assign eventsSet[`RBSC_EV_TXEND] = txDone;
  assign eventsSet[`RBSC_EV_AMATCH] = (state_r == RBSC_BUSY_RX) && phy.addrMatch;

  assign readMux = (bus.addr == `RBSC_ADDR_CMD) ? {3'h0, cmd_r} :
                   (bus.addr == `RBSC_ADDR_STATUS) ? {3'h0, statusCode} :
                   (bus.addr == `RBSC_ADDR_PIN) ? {7'h00, sleepTx_r} :
                   (bus.addr == `RBSC_ADDR_EVENT) ? {2'h0, events_r} :
                   (bus.addr == `RBSC_ADDR_CHANNEL) ? {3'h0, channel_r} :
                   (bus.addr == `RBSC_ADDR_RXINFO) ? {6'h00, locked_r, crcValid_r} : 8'h00;

  // Pin-control bit survives a soft reset; only the main reset clears it.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sleepTx_r <= 1'b0;
      sleepTxPrev_r <= 1'b0;
    end
    else
    begin
      if (pinWrite)
        sleepTx_r <= bus.wdata[`RBSC_PIN_SLEEP_BIT];
      sleepTxPrev_r <= sleepTx_r;
    end
  end

  // Radio registers and state return to defaults on either reset.
  always_ff @(posedge ref_clk)
  begin
    if (radioReset)
    begin
      state_r <= RBSC_OFF;
      cmd_r <= `RBSC_CMD_NOP;
      channel_r <= `RBSC_CHANNEL_RST;
      crcValid_r <= 1'b0;
      offPending_r <= 1'b0;
      locked_r <= 1'b0;
      regReady_r <= 1'b0;
      inTransit_r <= 1'b0;
      txSending_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (cmdWrite)
        cmd_r <= newCmd;
      if (chanWrite)
        channel_r <= bus.wdata[4:0];
      if (rxDone)
        crcValid_r <= phy.crcOk;
      if (state_nxt != state_r)
        offPending_r <= 1'b0;
      else if (isBusy && plainOff)
        offPending_r <= 1'b1;
      if (leaveAnalog)
        regReady_r <= 1'b0;
      else if (regDone)
        regReady_r <= 1'b1;
      if (leaveAnalog)
        locked_r <= 1'b0;
      else if (pllDone)
        locked_r <= 1'b1;
      inTransit_r <= (state_nxt != state_r);
      if (state_nxt != RBSC_BUSY_TX)
        txSending_r <= 1'b0;
      else if (rampDone)
        txSending_r <= 1'b1;
    end
  end

  // Awake also fires on the cycle that follows any reset, since off is entered then.
  logic resetSeen_r;
  always_ff @(posedge ref_clk)
  begin
    resetSeen_r <= radioReset;
    if (rst)
    begin
      events_r <= 6'h00;
      rdata_r <= 8'h00;
    end
    else
    begin
      events_r <= eventsSet | {5'h00, resetSeen_r && !softReset};
      rdata_r <= bus.rd ? readMux : 8'h00;
    end
  end

  assign rdata = rdata_r;
  assign events = events_r;
  assign channel = channel_r;
  assign regulatorOn = (state_r != RBSC_OFF) && (state_r != RBSC_SLEEP);
  assign synthOn = regulatorOn && (regReady_r || state_r != RBSC_PLL);
  assign rxOn = (state_r == RBSC_RX_LISTEN) || (state_r == RBSC_BUSY_RX);
  assign paOn = (state_r == RBSC_BUSY_TX) && txSending_r;
  assign txChipStart = rampDone && (state_nxt == RBSC_BUSY_TX);
  assign bufferWrite = (state_r == RBSC_BUSY_RX);
  assign memClear = (state_r == RBSC_SLEEP);
  assign frontEndOn = regulatorOn;
endmodule
`default_nettype wire

// file: rbsc_ctrl_monitor.sv
// Checker of the state controller outputs against their causes.
`default_nettype none
module rbsc_ctrl_monitor
  import rbsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire rbsc_bus_t bus,
  input wire logic [7:0] rdata,
  input wire rbsc_phy_t phy,
  input wire logic regulatorOn,
  input wire logic synthOn,
  input wire logic rxOn,
  input wire logic paOn,
  input wire logic txChipStart,
  input wire logic bufferWrite,
  input wire logic memClear,
  input wire logic frontEndOn,
  input wire logic [5:0] events
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_released;
    $fell(rst);
  endsequence
  sequence s_awake;
    ##[1:3] events[0];
  endsequence
  a_awake_reset: assert property (s_released |-> s_awake)
    else $error("awake event missing after reset");
  a_sleep_dark: assert property (memClear |-> !(regulatorOn | synthOn | rxOn | paOn | frontEndOn))
    else $error("radio circuit active while sleeping");
  a_synth_reg: assert property (synthOn |-> regulatorOn)
    else $error("synthesizer on without regulator");
  a_rx_stream: assert property (bufferWrite |-> rxOn && synthOn && !paOn)
    else $error("buffer written outside reception");
  a_chip_synth: assert property (txChipStart |-> synthOn && !rxOn)
    else $error("first chip without synthesizer");
  a_rx_end_cause: assert property (events[3] |-> $past(phy.frameDone))
    else $error("receive end without frame end");
  a_rx_start_cause: assert property (events[2] |-> $past(phy.phrValid))
    else $error("receive start without header");
  a_tx_end_cause: assert property (events[4] |-> $past(phy.txDone))
    else $error("transmit end without completion");
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside read answer");
endmodule
`default_nettype wire

// file: rbsc_host_model.sv
// Host core model that drives the register port of the state controller.
`default_nettype none
module rbsc_host_model
  import rbsc_pkg::*;
(
  input wire logic ref_clk,
  output var rbsc_bus_t bus,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bus = '0;
  // Called just after an edge; a last access leaves the port idle so strobes stay one cycle.
  task automatic put(input rbsc_bus_t b, input bit last);
    bus <= b;
    @(posedge ref_clk);
    if (last)
      bus <= '0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    put('{addr: a, wdata: v, wr: 1'b1, rd: 1'b0}, 1'b1);
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    put('{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1}, 1'b1);
    @(posedge ref_clk);
    v = rdata;
  endtask
endmodule
`default_nettype wire

// file: tb_radio_basic_state_control.sv
// Self-checking testbench of the radio state controller.
`default_nettype none
module tb_radio_basic_state_control import rbsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic rst;
  rbsc_bus_t bus;
  rbsc_phy_t phy;
  logic [7:0] rdata;
  logic rdPend;
  logic [7:0] d;
  logic [7:0] rnd;
  logic [8:0] e;
  logic [8:0] expQ[$];
  int errors;
  int total_checks;
  rbsc_ctrl dut(.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .phy(phy), .regulatorOn(), .synthOn(),
    .rxOn(), .paOn(), .txChipStart(), .bufferWrite(), .memClear(), .frontEndOn(), .channel(), .events());
  rbsc_host_model host(.ref_clk(ref_clk), .bus(bus), .rdata(rdata));
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Status polls are queued with bit 8 set so that the watcher skips them.
  always @(posedge ref_clk)
  begin
    if (rdPend)
    begin
      e = expQ.pop_front();
      if (!e[8])
        check(rdata, e[7:0]);
    end
    rdPend <= bus.rd;
  end
  task automatic chk(input logic [3:0] a, input logic [7:0] v);
    expQ.push_back({1'b0, v});
    host.rd(a, d);
  endtask
  task automatic st(input logic [4:0] c);
    int n;
    n = 0;
    d = 8'h1F;
    while (d === 8'h1F && n < 300)
    begin
      expQ.push_back(9'h100);
      host.rd(4'h1, d);
      n++;
    end
    if (n == 300)
    begin
      errors++;
      end_of_test();
    end
    chk(4'h1, {3'h0, c});
  endtask
  task automatic cmd(input logic [4:0] c, input logic [4:0] s);
    host.wr(4'h0, {3'h0, c});
    st(s);
  endtask
  task automatic pulse(input logic [5:0] p);
    phy <= rbsc_phy_t'(p);
    @(posedge ref_clk);
    phy <= '0;
    @(posedge ref_clk);
  endtask
  initial
  begin
    rst = 1'b1;
    phy = '0;
    rdPend = 1'b0;
    errors = 0;
    total_checks = 0;
    void'($urandom(32'h160d));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk(4'h1, 8'h08);
    chk(4'h4, 8'h0B);
    chk(4'hF, 8'h00);
    host.put('{addr: 4'h0, wdata: 8'h09, wr: 1'b1, rd: 1'b0}, 1'b0);
    expQ.push_back(9'h01F);
    host.put('{addr: 4'h1, wdata: 8'h00, wr: 1'b0, rd: 1'b1}, 1'b1);
    @(posedge ref_clk);
    st(5'h09);
    repeat (30) @(posedge ref_clk);
    cmd(5'h02, 5'h02);
    repeat (170) @(posedge ref_clk);
    pulse(6'h01);
    st(5'h09);
    cmd(5'h06, 5'h06);
    pulse(6'h20);
    pulse(6'h10);
    st(5'h01);
    cmd(5'h08, 5'h01);
    pulse(6'h0E);
    st(5'h08);
    chk(4'h5, 8'h01);
    cmd(5'h09, 5'h09);
    repeat (30) @(posedge ref_clk);
    chk(4'h5, 8'h03);
    cmd(5'h06, 5'h06);
    pulse(6'h20);
    cmd(5'h04, 5'h09);
    cmd(5'h02, 5'h02);
    cmd(5'h03, 5'h08);
    cmd(5'h02, 5'h08);
    host.wr(4'h2, 8'h01);
    st(5'h0F);
    cmd(5'h04, 5'h0F);
    host.wr(4'h2, 8'h00);
    st(5'h08);
    rnd = 8'($urandom % 32);
    host.wr(4'h4, rnd);
    chk(4'h4, rnd);
    host.wr(4'h2, 8'h01);
    st(5'h0F);
    host.wr(4'h2, 8'h03);
    st(5'h08);
    chk(4'h4, 8'h0B);
    host.wr(4'h2, 8'h00);
    end_of_test();
  end
endmodule
bind rbsc_ctrl rbsc_ctrl_monitor u_mon(.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .phy(phy),
  .regulatorOn(regulatorOn), .synthOn(synthOn), .rxOn(rxOn), .paOn(paOn), .txChipStart(txChipStart),
  .bufferWrite(bufferWrite), .memClear(memClear), .frontEndOn(frontEndOn), .events(events));
`default_nettype wire
